// [hw/hci_interlock_irq.sv]
// Purpose: Interlock control and interrupt status registers of a USB hub
// Assumes: Register port driven by the serial slave on ref_clk
// Notes:   Mask bits arrive as inputs; the mask register lives elsewhere
// Behaviour
// - Interlock register resets to 0x32; connect waits for a serial write.
// - Interlock bit 5 high uses the active-low over-current pin, else register.
// - Interlock bit 4 high drives the power pin, else pin off.
// - Connect hold bit high keeps the hub in the connect stage.
// - Connect hold bit low moves the hub into the communication stage.
// - Config hold bit high keeps configuration stage; interlock writes are open in every stage.
// - Serial write clearing config hold leaves configuration stage at once.
// - Without any interlock write, configuration stage ends after the timeout.
// - Status bit 7 reads 1 while interrupt pin is low from unmasked event.
// - Writing 0 to status bit 7 releases the pin; 1 has no effect.
// - Status bit 4 sets on hub suspend, cleared only by writing 0.
// - Status bit 3 sets on host configuration, cleared by writing 0.
// - Status bit 2 sets on port power update, cleared by writing 0.
// - Suspend pulls the interrupt pin low only when its enable is 1.
// - Host configuration pulls the pin low only when its enable is 1.
`timescale 1ns/1ps
module hci_interlock_irq
    import hci_pkg::*;
#(
    parameter int unsigned CFG_TIMEOUT_CYC = HCI_CFG_TOUT_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr_en,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd_en,
    output logic      [7:0] reg_rdata,
    input  wire logic       overcurrent_input_low,
    input  wire logic       overcurrent_reg_flag,
    output logic            overcurrent_detect,
    input  wire logic       port_power_request,
    output logic            port_power_switch_out,
    output logic            port_power_switch_oe_b,
    input  wire logic       hub_suspend_enter,
    input  wire logic       host_configured,
    input  wire logic       port_power_updated,
    input  wire logic       suspend_event_enable,
    input  wire logic       configured_event_enable,
    input  wire logic       port_power_event_enable,
    output logic            irq_pin_low_b,
    output logic            stage_config,
    output logic            stage_connect,
    output logic            stage_comm
);
    logic [7:0]             serial_interlock_control;
    logic [7:0]             next_ilock;
    logic                   ilock_written;
    logic                   next_ilock_written;
    hci_stage_t             stage;
    hci_stage_t             next_stage;
    logic [HCI_TIMER_W-1:0] cfg_timer;
    logic [HCI_TIMER_W-1:0] next_cfg_timer;
    logic                   timer_done;
    logic                   ilock_wr;
    logic                   status_wr;
    logic                   oc_meta;
    logic                   oc_sync;
    logic                   next_oc_detect;
    logic                   next_pwr_out;
    logic                   next_pwr_oe_b;
    logic [7:0]             next_rdata;
    logic                   suspend_event_flag;
    logic                   host_configured_flag;
    logic                   port_power_update_flag;
    logic                   irq_asserted;
    logic                   irq_set;
    logic                   overcurrent_pin_select;
    logic                   power_pin_select;

    assign ilock_wr  = reg_wr_en && (reg_addr == HCI_ILOCK_OFS);
    assign status_wr = reg_wr_en && (reg_addr == HCI_STATUS_OFS);
    assign timer_done = (cfg_timer == HCI_TIMER_W'(CFG_TIMEOUT_CYC - 1));
    assign overcurrent_pin_select = serial_interlock_control[HCI_ILOCK_OCS_BIT];
    assign power_pin_select = serial_interlock_control[HCI_ILOCK_PWR_BIT];

    // Interlock register; reserved bits are never stored
    always_comb begin
        next_ilock         = serial_interlock_control;
        next_ilock_written = ilock_written;
        if (ilock_wr) begin
            next_ilock         = reg_wdata & HCI_ILOCK_WMASK;
            next_ilock_written = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            serial_interlock_control <= HCI_ILOCK_RESET;
            ilock_written            <= 1'b0;
        end else begin
            serial_interlock_control <= next_ilock;
            ilock_written            <= next_ilock_written;
        end
    end

    // Hub stage sequencing
    always_comb begin
        next_stage     = stage;
        next_cfg_timer = cfg_timer;
        case (stage)
            HCI_ST_CONFIG: begin
                if (!timer_done) begin
                    next_cfg_timer = cfg_timer + 1'b1;
                end
                if (ilock_wr) begin
                    if (!reg_wdata[HCI_ILOCK_CFG_BIT]) begin
                        next_stage = HCI_ST_CONNECT;
                    end
                end else if (!ilock_written && timer_done) begin
                    next_stage = HCI_ST_CONNECT;
                end else if (ilock_written &&
                             !serial_interlock_control[HCI_ILOCK_CFG_BIT]) begin
                    next_stage = HCI_ST_CONNECT;
                end
            end
            HCI_ST_CONNECT: begin
                if (!serial_interlock_control[HCI_ILOCK_CON_BIT]) begin
                    next_stage = HCI_ST_COMM;
                end
            end
            HCI_ST_COMM: begin
                next_stage = HCI_ST_COMM;
            end
            default: begin
                next_stage = HCI_ST_CONFIG;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            stage     <= HCI_ST_CONFIG;
            cfg_timer <= '0;
        end else begin
            stage     <= next_stage;
            cfg_timer <= next_cfg_timer;
        end
    end

    // Stage outputs; interlock writes are accepted in every stage
    assign stage_config  = (stage == HCI_ST_CONFIG);
    assign stage_connect = (stage == HCI_ST_CONNECT);
    assign stage_comm    = (stage == HCI_ST_COMM);

    // Over-current pin comes from another domain: two flops first
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            oc_meta <= 1'b1;
            oc_sync <= 1'b1;
        end else begin
            oc_meta <= overcurrent_input_low;
            oc_sync <= oc_meta;
        end
    end

    always_comb begin
        next_oc_detect = overcurrent_pin_select ? !oc_sync
                                                : overcurrent_reg_flag;
        next_pwr_out   = power_pin_select && port_power_request;
        next_pwr_oe_b  = !power_pin_select;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            overcurrent_detect     <= 1'b0;
            port_power_switch_out  <= 1'b0;
            port_power_switch_oe_b <= 1'b1;
        end else begin
            overcurrent_detect     <= next_oc_detect;
            port_power_switch_out  <= next_pwr_out;
            port_power_switch_oe_b <= next_pwr_oe_b;
        end
    end

    // Status flags: writing 1 leaves a flag alone, writing 0 clears it
    hci_sticky_flag u_susp_flag (
        .ref_clk     (ref_clk),
        .rst_b       (rst_b),
        .set_pulse   (hub_suspend_enter),
        .clear_pulse (status_wr && !reg_wdata[HCI_ST_SUSP_BIT]),
        .flag        (suspend_event_flag)
    );

    hci_sticky_flag u_cfg_flag (
        .ref_clk     (ref_clk),
        .rst_b       (rst_b),
        .set_pulse   (host_configured),
        .clear_pulse (status_wr && !reg_wdata[HCI_ST_CFG_BIT]),
        .flag        (host_configured_flag)
    );

    hci_sticky_flag u_pwr_flag (
        .ref_clk     (ref_clk),
        .rst_b       (rst_b),
        .set_pulse   (port_power_updated),
        .clear_pulse (status_wr && !reg_wdata[HCI_ST_PWR_BIT]),
        .flag        (port_power_update_flag)
    );

    // Only enabled events reach the pin
    assign irq_set = (hub_suspend_enter && suspend_event_enable) ||
                     (host_configured && configured_event_enable) ||
                     (port_power_updated && port_power_event_enable);

    hci_sticky_flag u_irq_flag (
        .ref_clk     (ref_clk),
        .rst_b       (rst_b),
        .set_pulse   (irq_set),
        .clear_pulse (status_wr && !reg_wdata[HCI_ST_IRQ_BIT]),
        .flag        (irq_asserted)
    );

    // Pin follows the flag directly so read-back and pin never disagree
    assign irq_pin_low_b = !irq_asserted;

    // Registered read data; unmapped addresses read zero
    always_comb begin
        next_rdata = reg_rdata;
        if (reg_rd_en) begin
            next_rdata = HCI_READ_ZERO;
            if (reg_addr == HCI_ILOCK_OFS) begin
                next_rdata = serial_interlock_control;
            end else if (reg_addr == HCI_STATUS_OFS) begin
                next_rdata[HCI_ST_IRQ_BIT]  = irq_asserted;
                next_rdata[HCI_ST_SUSP_BIT] = suspend_event_flag;
                next_rdata[HCI_ST_CFG_BIT]  = host_configured_flag;
                next_rdata[HCI_ST_PWR_BIT]  = port_power_update_flag;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            reg_rdata <= HCI_READ_ZERO;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    a_ilock_reset_value: assert property ($past(!rst_b) |->
        serial_interlock_control == HCI_ILOCK_RESET && !irq_asserted)
        else $error("Interlock or status wrong after reset");

    a_oc_pin_select: assert property (
        $past(overcurrent_pin_select) |-> overcurrent_detect == !$past(oc_sync))
        else $error("Over-current pin not followed");

    a_power_pin_off: assert property (
        !power_pin_select |=> port_power_switch_oe_b && !port_power_switch_out)
        else $error("Power pin driven while deselected");

    a_connect_hold: assert property (
        stage_connect && serial_interlock_control[HCI_ILOCK_CON_BIT]
        |=> stage_connect)
        else $error("Left connect stage while held");

    a_connect_release: assert property (
        stage_connect && !serial_interlock_control[HCI_ILOCK_CON_BIT]
        |=> stage_comm)
        else $error("Connect stage not released");

    a_config_hold: assert property (
        stage_config && ilock_written &&
        serial_interlock_control[HCI_ILOCK_CFG_BIT] && !ilock_wr
        |=> stage_config)
        else $error("Left config stage while held");

    a_config_exit: assert property (
        stage_config && ilock_wr && !reg_wdata[HCI_ILOCK_CFG_BIT]
        |=> stage_connect)
        else $error("Config stage not left on write");

    a_timeout_exit: assert property (
        stage_config && !ilock_written && !ilock_wr && timer_done
        |=> stage_connect)
        else $error("Config timeout ignored");

    a_irq_release: assert property (
        status_wr && !reg_wdata[HCI_ST_IRQ_BIT] && !irq_set
        |=> irq_pin_low_b && !irq_asserted)
        else $error("Interrupt pin not released");

    a_irq_keep: assert property (
        irq_asserted && status_wr && reg_wdata[HCI_ST_IRQ_BIT]
        |=> !irq_pin_low_b)
        else $error("Interrupt dropped on write of one");

    a_suspend_sticky: assert property (
        hub_suspend_enter ||
        (suspend_event_flag && !(status_wr && !reg_wdata[HCI_ST_SUSP_BIT]))
        |=> suspend_event_flag)
        else $error("Suspend flag not held");

    a_suspend_masked: assert property (
        !irq_asserted && hub_suspend_enter && !suspend_event_enable &&
        !(host_configured && configured_event_enable) &&
        !(port_power_updated && port_power_event_enable)
        |=> !irq_asserted)
        else $error("Masked suspend drove interrupt");

    a_cfg_event_irq: assert property (
        host_configured && configured_event_enable ##1 !status_wr
        |=> !irq_pin_low_b && host_configured_flag)
        else $error("Enabled configuration event lost");
endmodule

// [hw/hci_sticky_flag.sv]
// Purpose: One sticky event flag, set by hardware, cleared by software
// Assumes: Set and clear are pulses on ref_clk
// Notes:   Set wins over a clear in the same cycle so no event is lost
`timescale 1ns/1ps
module hci_sticky_flag (
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic set_pulse,
    input  wire logic clear_pulse,
    output logic      flag
);
    logic next_flag;

    always_comb begin
        next_flag = flag;
        if (set_pulse) begin
            next_flag = 1'b1;
        end else if (clear_pulse) begin
            next_flag = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end
endmodule

// [inc/hci_pkg.sv]
// Purpose: Shared constants of the hub configuration interlock block
// Assumes: 100 MHz core clock
// Notes:   Register offsets are the serial port byte addresses
package hci_pkg;

    localparam logic [7:0] HCI_ILOCK_OFS     = 8'hE7;
    localparam logic [7:0] HCI_STATUS_OFS    = 8'hE8;

    localparam logic [7:0] HCI_ILOCK_RESET   = 8'h32;
    localparam logic [7:0] HCI_ILOCK_WMASK   = 8'h33;
    localparam logic [7:0] HCI_READ_ZERO     = 8'h00;

    localparam int         HCI_ILOCK_CFG_BIT = 0;
    localparam int         HCI_ILOCK_CON_BIT = 1;
    localparam int         HCI_ILOCK_PWR_BIT = 4;
    localparam int         HCI_ILOCK_OCS_BIT = 5;

    localparam int         HCI_ST_PWR_BIT    = 2;
    localparam int         HCI_ST_CFG_BIT    = 3;
    localparam int         HCI_ST_SUSP_BIT   = 4;
    localparam int         HCI_ST_IRQ_BIT    = 7;

    localparam int         HCI_CLK_PERIOD_NS = 10;
    localparam int         HCI_CFG_TOUT_NS   = 95000000;
    localparam int         HCI_CFG_TOUT_CYC  =
        (HCI_CFG_TOUT_NS + HCI_CLK_PERIOD_NS - 1) / HCI_CLK_PERIOD_NS;
    localparam int         HCI_TIMER_W       = 24;

    typedef enum logic [2:0] {
        HCI_ST_CONFIG  = 3'b001,
        HCI_ST_CONNECT = 3'b010,
        HCI_ST_COMM    = 3'b100
    } hci_stage_t;

endpackage

// [tb/hci_interlock_irq_test.sv]
// Purpose: Self-checking bench of the interlock and status block
// Assumes: Timeout shortened to 20 cycles
// Notes:   Random pins and enables come from an xorshift stream
`timescale 1ns/1ps
module hci_interlock_irq_test
    import hci_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        rst_b   = 1'b0;
    logic [7:0]  reg_addr;
    logic        reg_wr_en;
    logic [7:0]  reg_wdata;
    logic        reg_rd_en;
    logic [7:0]  reg_rdata;
    logic        oc_pin  = 1'b1;
    logic        oc_reg  = 1'b0;
    logic        oc_det;
    logic        pwr_req = 1'b0;
    logic        pwr_out;
    logic        pwr_oe_b;
    logic [2:0]  ev      = 3'h0;
    logic [2:0]  en      = 3'h0;
    logic        irq_b;
    logic        st_cfg;
    logic        st_con;
    logic        st_com;
    logic [31:0] seed    = 32'h9495;
    logic [7:0]  v;
    int          n_errors  = 0;
    int          cmp_count = 0;
    int          i;
    int          e;

    always #5 ref_clk = ~ref_clk;

    hci_interlock_irq #(.CFG_TIMEOUT_CYC(20)) u_hci_interlock_irq (
        .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
        .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
        .overcurrent_input_low(oc_pin), .overcurrent_reg_flag(oc_reg),
        .overcurrent_detect(oc_det), .port_power_request(pwr_req),
        .port_power_switch_out(pwr_out), .port_power_switch_oe_b(pwr_oe_b),
        .hub_suspend_enter(ev[0]), .host_configured(ev[1]),
        .port_power_updated(ev[2]), .suspend_event_enable(en[0]),
        .configured_event_enable(en[1]), .port_power_event_enable(en[2]),
        .irq_pin_low_b(irq_b), .stage_config(st_cfg),
        .stage_connect(st_con), .stage_comm(st_com)
    );

    hci_proc_model u_hci_proc_model (
        .ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
        .reg_rdata(reg_rdata)
    );

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Event 0, 1, 2 land on status bits 4, 3, 2
    function automatic logic [7:0] exp_st(int k, logic m);
        logic [7:0] s;
        s = 8'h00;
        s[HCI_ST_SUSP_BIT - k] = 1'b1;
        s[HCI_ST_IRQ_BIT] = m;
        return s;
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic do_reset();
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Random pins, then let the sync stages settle
    task automatic pins();
        @(posedge ref_clk);
        v = 8'(rnd());
        oc_pin <= v[0];
        oc_reg <= v[1];
        pwr_req <= v[2];
        tick(4);
    endtask

    initial begin
        do_reset();
        u_hci_proc_model.rd(HCI_ILOCK_OFS, v);
        chk(v, 8'h32);
        u_hci_proc_model.rd(HCI_STATUS_OFS, v);
        chk(v, 8'h00);
        chk({7'h00, irq_b}, 8'h01);
        for (i = 0; i < 40 && st_con !== 1'b1; i++) tick(1);
        if (st_con !== 1'b1) begin
            n_errors++;
            stop_test();
        end
        chk({7'h00, st_cfg}, 8'h00);
        tick(10);
        chk({7'h00, st_con}, 8'h01);
        u_hci_proc_model.wr(HCI_ILOCK_OFS, 8'h30);
        tick(3);
        chk({7'h00, st_com}, 8'h01);
        do_reset();
        u_hci_proc_model.setup(8'hFF);
        u_hci_proc_model.wr(8'hE6, 8'h00);
        u_hci_proc_model.rd(HCI_ILOCK_OFS, v);
        chk(v, 8'h33);
        u_hci_proc_model.rd(8'hE6, v);
        chk(v, 8'h00);
        tick(30);
        chk({7'h00, st_cfg}, 8'h01);
        for (i = 0; i < 8; i++) begin
            pins();
            chk({7'h00, oc_det}, {7'h00, ~oc_pin});
            chk({6'h00, pwr_out, pwr_oe_b}, {6'h00, pwr_req, 1'b0});
        end
        u_hci_proc_model.release_cfg(8'h02);
        tick(1);
        chk({6'h00, st_cfg, st_con}, 8'h01);
        for (i = 0; i < 8; i++) begin
            pins();
            chk({7'h00, oc_det}, {7'h00, oc_reg});
            chk({6'h00, pwr_out, pwr_oe_b}, 8'h01);
        end
        for (i = 0; i < 12; i++) begin
            e = i % 3;
            @(posedge ref_clk);
            v = 8'(rnd());
            en <= v[2:0];
            @(posedge ref_clk);
            ev[e] <= 1'b1;
            @(posedge ref_clk);
            ev <= 3'h0;
            u_hci_proc_model.rd(HCI_STATUS_OFS, v);
            chk(v, exp_st(e, en[e]));
            chk({7'h00, irq_b}, {7'h00, ~en[e]});
            u_hci_proc_model.wr(HCI_STATUS_OFS, 8'hFF);
            u_hci_proc_model.rd(HCI_STATUS_OFS, v);
            chk(v, exp_st(e, en[e]));
            u_hci_proc_model.wr(HCI_STATUS_OFS, 8'h00);
            u_hci_proc_model.rd(HCI_STATUS_OFS, v);
            chk(v, 8'h00);
            chk({7'h00, irq_b}, 8'h01);
        end
        stop_test();
    end
endmodule

// [tb/hci_proc_model.sv]
// Purpose: System processor model on the register port
// Assumes: One byte per access, strobes one cycle long
// Notes:   Idle address and data show the inverse of the last value
`timescale 1ns/1ps
module hci_proc_model (
    input  wire logic       ref_clk,
    output logic      [7:0] reg_addr,
    output logic            reg_wr_en,
    output logic      [7:0] reg_wdata,
    output logic            reg_rd_en,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wr_en = 1'b0;
        reg_wdata = 8'h00;
        reg_rd_en = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr_en <= 1'b1;
        @(posedge ref_clk);
        reg_wr_en <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge ref_clk);
        reg_rd_en <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask

    // Interlock is written first so only it races the timeout
    task automatic setup(input logic [7:0] hold);
        wr(8'hE7, hold);
    endtask

    task automatic release_cfg(input logic [7:0] fin);
        wr(8'hE7, fin);
    endtask
endmodule
